// File: rtl/ebc_cfg.svh
// offsets, field positions, reset values and widths of the port control block
`ifndef EBC_CFG_SVH
`define EBC_CFG_SVH
`define EBC_ADR_W 18
`define EBC_IDX_W 16
`define EBC_BCR_IDX 16'hffde
`define EBC_BUS_CONTROL_SECOND_IDX 16'hffda
`define EBC_BH_BIT 15
`define EBC_BS_BIT 14
`define EBC_GFL_BIT 13
`define EBC_PAD_BIT 12
`define EBC_XWS_HI 9
`define EBC_XWS_LO 5
`define EBC_PWS_HI 4
`define EBC_PWS_LO 0
`define EBC_SPLIT_BIT 15
`define EBC_EWS_HI 4
`define EBC_EWS_LO 0
`define EBC_BCR_RST 16'h0021
`define EBC_BUS_CONTROL_SECOND_RST 16'h0000
`define EBC_BCR_WMASK 16'hb3ff
`define EBC_BUS_CONTROL_SECOND_WMASK 16'h801f
`define EBC_WS_ZERO 5'h00
`define EBC_WS_ONE 5'h01
`endif

// File: rtl/ebc_pkg.sv
// types shared by the port control block
package ebc_pkg;
  typedef enum logic [1:0] {
    EBC_SP_PROG,
    EBC_SP_DATA,
    EBC_SP_PERIPH
  } ebc_space_t;
  typedef enum logic {
    EBC_ST_IDLE,
    EBC_ST_RUN
  } ebc_acc_st_t;
endpackage : ebc_pkg

// File: rtl/ebc_pin_keeper.sv
// reset-initialised keeper for a two-way active-low control pin
`timescale 1ns/1ps
module ebc_pin_keeper (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic force_low,
  // pad
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_level
);
  logic sync1_r;
  logic sync2_r;
  logic held_r;
  logic echo1_r;
  logic echo2_r;

  // the pad reads back our own keeper level two cycles late; only a
  // sample that differs from that echo came from another driver, so
  // an old level cannot keep circulating through the loop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      echo1_r <= 1'b1;
      echo2_r <= 1'b1;
    end else begin
      echo1_r <= pin_out;
      echo2_r <= echo1_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // last level seen on the pad, whoever drove it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      held_r <= 1'b1;
    end else if (force_low) begin
      held_r <= 1'b0;
    end else if (sync2_r != echo2_r) begin
      held_r <= sync2_r; // RULE9
    end
  end

  // pad drives high during reset so the pin leaves reset in its idle state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= 1'b1; // RULE11
      pin_oe <= 1'b1;
    end else begin
      pin_out <= force_low ? 1'b0 : held_r; // RULE8
      pin_oe <= force_low;
    end
  end

  assign pin_level = sync2_r;
endmodule : ebc_pin_keeper

// File: rtl/ebc_regs.sv
// classic wishbone slave holding both bus control registers
`timescale 1ns/1ps
`include "ebc_cfg.svh"
module ebc_regs (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`EBC_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // status in
  input wire logic bus_state,
  // fields out
  output logic [15:0] bcr_q,
  output logic [15:0] bus_control_second_q
);
  logic req;
  logic hit_bcr;
  logic hit_bus_control_second;
  logic [15:0] lane_m;
  logic first_r;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign hit_bcr = wb_adr_i[1:0] == 2'h0 &&
    wb_adr_i[`EBC_ADR_W-1:2] == `EBC_BCR_IDX;
  assign hit_bus_control_second = wb_adr_i[1:0] == 2'h0 &&
    wb_adr_i[`EBC_ADR_W-1:2] == `EBC_BUS_CONTROL_SECOND_IDX;
  assign lane_m = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // one wait-free answer; unmapped addresses ack with zero data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bcr_q <= `EBC_BCR_RST; // RULE10 RULE16
    end else if (req && wb_we_i && hit_bcr) begin
      bcr_q <= (bcr_q & ~(lane_m & `EBC_BCR_WMASK)) |
        (wb_dat_i[15:0] & lane_m & `EBC_BCR_WMASK);
    end
  end

  // reserved positions stay zero whatever software writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_control_second_q <= `EBC_BUS_CONTROL_SECOND_RST; // RULE5 RULE12
    end else if (req && wb_we_i && hit_bus_control_second) begin
      bus_control_second_q <= (bus_control_second_q & ~(lane_m & `EBC_BUS_CONTROL_SECOND_WMASK)) |
        (wb_dat_i[15:0] & lane_m & `EBC_BUS_CONTROL_SECOND_WMASK); // RULE4 RULE13
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i && hit_bcr) begin
      wb_dat_o <= {16'h0000, bcr_q[`EBC_BH_BIT], bus_state,
        bcr_q[`EBC_GFL_BIT:0]};
    end else if (req && !wb_we_i && hit_bus_control_second) begin
      wb_dat_o <= {16'h0000, bus_control_second_q};
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      first_r <= 1'b0;
    end else begin
      first_r <= 1'b1;
    end
  end

  a_reset_fields: assert property ( // RULE5 RULE10 RULE12 RULE16
    @(posedge clk) disable iff (!reset_n)
    !first_r |-> bus_control_second_q == `EBC_BUS_CONTROL_SECOND_RST && !bcr_q[`EBC_GFL_BIT] &&
      !bcr_q[`EBC_PAD_BIT])
    else $error("control fields not cleared by reset");
endmodule : ebc_regs

// File: rtl/ebc_top.sv
// external port chip-enable, grant pull-down and program address gating
// Contract
// [RULE1] legacy: memory strobe on every external access
// [RULE2] peripheral strobe only during peripheral accesses
// [RULE3] split: memory strobe never on peripheral access
// [RULE4] split control is bit 15 of second register
// [RULE5] reset clears split control
// [RULE6] clearing split restores legacy strobes
// [RULE7] split acts only in bus master mode
// [RULE8] master mode: grant pin high, forced low
// [RULE9] cleared pull-down keeps last grant level
// [RULE10] reset clears grant pull-down bit
// [RULE11] control and debug pins idle after reset
// [RULE12] peripheral wait field resets to zero
// [RULE13] software writes zero to reserved bits
// [RULE14] disable blocks program address from pins
// [RULE15] disable leaves data and peripheral accesses
// [RULE16] disable is bit 12, reset clears
// [RULE17] software avoids program access while disabled
// [RULE18] software waits one cycle after clearing
// [RULE19] strobes low for whole access incl waits
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "ebc_cfg.svh"
module ebc_top (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`EBC_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core access request
  input wire logic master_mode,
  input wire logic acc_start,
  input wire ebc_pkg::ebc_space_t acc_space,
  input wire logic [15:0] acc_addr,
  input wire logic [15:0] program_address_bus,
  output logic acc_done,
  // port strobes and address
  output logic memory_chip_enable_n,
  output logic peripheral_select_n,
  output logic [15:0] port_address,
  output logic bus_request_hold,
  // grant pin
  input wire logic grant_pin_n_in,
  output logic grant_pin_n_out,
  output logic grant_pin_n_oe,
  // debug request pin
  input wire logic debug_request_pin_n_in,
  output logic debug_request_pin_n_out,
  output logic debug_request_pin_n_oe
);
  import ebc_pkg::*;

  logic [15:0] bcr_q;
  logic [15:0] bus_control_second_q;
  logic split_strobe_enable;
  logic grant_force_low;
  logic program_addr_out_disable;
  logic [4:0] prog_ws;
  logic [4:0] data_ws;
  logic [4:0] periph_ws;
  logic [4:0] start_ws;
  logic grant_level;
  logic master_sync1_r;
  logic master_r;
  logic eff_split_r;
  ebc_space_t space_r;
  ebc_acc_st_t st_r;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic last_cycle;

  ebc_regs u_regs (
    .clk(clk),
    .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .bus_state(~grant_level),
    .bcr_q(bcr_q),
    .bus_control_second_q(bus_control_second_q)
  );

  assign split_strobe_enable = bus_control_second_q[`EBC_SPLIT_BIT]; // RULE4
  assign grant_force_low = bcr_q[`EBC_GFL_BIT];
  assign program_addr_out_disable = bcr_q[`EBC_PAD_BIT]; // RULE16
  assign prog_ws = bcr_q[`EBC_PWS_HI:`EBC_PWS_LO];
  assign data_ws = bcr_q[`EBC_XWS_HI:`EBC_XWS_LO];
  assign periph_ws = bus_control_second_q[`EBC_EWS_HI:`EBC_EWS_LO];

  // the mode strap is a pin, so it is synchronised before use
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      master_sync1_r <= 1'b0;
      master_r <= 1'b0;
    end else begin
      master_sync1_r <= master_mode;
      master_r <= master_sync1_r;
    end
  end

  // pull-down only means anything while this side is bus master
  ebc_pin_keeper u_grant (
    .clk(clk),
    .reset_n(reset_n),
    .force_low(grant_force_low && master_r), // RULE8
    .pin_in(grant_pin_n_in),
    .pin_out(grant_pin_n_out),
    .pin_oe(grant_pin_n_oe),
    .pin_level(grant_level)
  );

  ebc_pin_keeper u_debug (
    .clk(clk),
    .reset_n(reset_n),
    .force_low(1'b0),
    .pin_in(debug_request_pin_n_in),
    .pin_out(debug_request_pin_n_out), // RULE11
    .pin_oe(debug_request_pin_n_oe),
    .pin_level()
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_request_hold <= 1'b0;
    end else begin
      bus_request_hold <= bcr_q[`EBC_BH_BIT];
    end
  end

  always_comb begin
    case (acc_space)
      EBC_SP_PROG: start_ws = prog_ws;
      EBC_SP_DATA: start_ws = data_ws;
      EBC_SP_PERIPH: start_ws = periph_ws;
      default: start_ws = `EBC_WS_ZERO;
    endcase
  end

  assign last_cycle = st_r == EBC_ST_RUN && cnt_r == `EBC_WS_ZERO;
  assign cnt_nxt = cnt_r - `EBC_WS_ONE;

  // access sequencer: one strobe cycle plus the wait states of the space
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= EBC_ST_IDLE;
      cnt_r <= `EBC_WS_ZERO;
    end else begin
      case (st_r)
        EBC_ST_IDLE: begin
          if (acc_start) begin
            st_r <= EBC_ST_RUN;
            cnt_r <= start_ws;
          end
        end
        EBC_ST_RUN: begin
          if (cnt_r == `EBC_WS_ZERO) begin
            st_r <= EBC_ST_IDLE;
          end else begin
            cnt_r <= cnt_nxt; // RULE19
          end
        end
        default: st_r <= EBC_ST_IDLE;
      endcase
    end
  end

  // mode is caught at the start so a register write mid-access cannot
  // glitch a strobe already on the pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eff_split_r <= 1'b0;
      space_r <= EBC_SP_DATA;
    end else if (st_r == EBC_ST_IDLE && acc_start) begin
      eff_split_r <= split_strobe_enable && master_r; // RULE6 RULE7
      space_r <= acc_space;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      memory_chip_enable_n <= 1'b1; // RULE11
      peripheral_select_n <= 1'b1;
    end else if (st_r == EBC_ST_IDLE && acc_start) begin
      memory_chip_enable_n <= split_strobe_enable && master_r &&
        acc_space == EBC_SP_PERIPH; // RULE1 RULE3
      peripheral_select_n <= acc_space != EBC_SP_PERIPH; // RULE2
    end else if (last_cycle) begin
      memory_chip_enable_n <= 1'b1; // RULE19
      peripheral_select_n <= 1'b1;
    end
  end

  // gating the fetch address saves pin toggling; a program access
  // while gated keeps a stale address, which software must avoid
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_address <= 16'h0000;
    end else if (st_r == EBC_ST_IDLE && acc_start) begin
      if (acc_space != EBC_SP_PROG) begin
        port_address <= acc_addr; // RULE15
      end else if (!program_addr_out_disable) begin
        port_address <= program_address_bus; // RULE14
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_done <= 1'b0;
    end else begin
      acc_done <= last_cycle;
    end
  end

  a_legacy_mem_ce: assert property ( // RULE1
    @(posedge clk) disable iff (!reset_n)
    st_r == EBC_ST_RUN && !eff_split_r |-> !memory_chip_enable_n)
    else $error("memory strobe missing in combined mode");

  a_periph_only: assert property ( // RULE2
    @(posedge clk) disable iff (!reset_n)
    !peripheral_select_n |-> st_r == EBC_ST_RUN && space_r == EBC_SP_PERIPH)
    else $error("peripheral strobe outside peripheral access");

  a_split_no_mem: assert property ( // RULE3
    @(posedge clk) disable iff (!reset_n)
    st_r == EBC_ST_RUN && eff_split_r && space_r == EBC_SP_PERIPH
      |-> memory_chip_enable_n && !peripheral_select_n)
    else $error("memory strobe during split peripheral access");

  a_split_select: assert property ( // RULE4 RULE6
    @(posedge clk) disable iff (!reset_n)
    st_r == EBC_ST_IDLE && acc_start |=>
      eff_split_r == ($past(split_strobe_enable) && $past(master_r)))
    else $error("split mode not taken from control bit");

  a_slave_legacy: assert property ( // RULE7
    @(posedge clk) disable iff (!reset_n)
    st_r == EBC_ST_IDLE && acc_start && !master_r &&
      acc_space == EBC_SP_PERIPH |=> !memory_chip_enable_n)
    else $error("split behaviour seen in slave mode");

  a_grant_force: assert property ( // RULE8
    @(posedge clk) disable iff (!reset_n)
    grant_force_low && master_r |-> ##[1:2]
      (grant_pin_n_oe && !grant_pin_n_out))
    else $error("grant pin not pulled low");

  a_pab_block: assert property ( // RULE14
    @(posedge clk) disable iff (!reset_n)
    st_r == EBC_ST_IDLE && acc_start && acc_space == EBC_SP_PROG &&
      program_addr_out_disable |=> $stable(port_address))
    else $error("program address reached pins while gated");

  a_data_pass: assert property ( // RULE15
    @(posedge clk) disable iff (!reset_n)
    st_r == EBC_ST_IDLE && acc_start && acc_space != EBC_SP_PROG
      |=> port_address == $past(acc_addr))
    else $error("data address not driven");

  a_zero_wait: assert property ( // RULE19
    @(posedge clk) disable iff (!reset_n)
    st_r == EBC_ST_IDLE && acc_start && start_ws == `EBC_WS_ZERO |=>
      (st_r == EBC_ST_RUN && !(memory_chip_enable_n &&
      peripheral_select_n)) ##1 (acc_done && memory_chip_enable_n &&
      peripheral_select_n))
    else $error("zero-wait access length wrong");

  a_one_wait: assert property ( // RULE19
    @(posedge clk) disable iff (!reset_n)
    st_r == EBC_ST_IDLE && acc_start && start_ws == `EBC_WS_ONE &&
      acc_space != EBC_SP_PERIPH |=> (!memory_chip_enable_n)[*2]
      ##1 (memory_chip_enable_n && acc_done))
    else $error("one-wait access length wrong");

  c_split_periph: cover property (
    @(posedge clk) disable iff (!reset_n)
    st_r == EBC_ST_RUN && eff_split_r && space_r == EBC_SP_PERIPH);

  c_legacy_periph: cover property (
    @(posedge clk) disable iff (!reset_n)
    st_r == EBC_ST_RUN && !eff_split_r && space_r == EBC_SP_PERIPH);

  c_gated_fetch: cover property (
    @(posedge clk) disable iff (!reset_n)
    acc_start && acc_space == EBC_SP_PROG && program_addr_out_disable);

  c_grant_low: cover property (
    @(posedge clk) disable iff (!reset_n)
    grant_pin_n_oe && !grant_pin_n_out);
endmodule : ebc_top

// File: dv/ebc_far_side.sv
// far-side model: another bus master sharing the active-low grant pin
`timescale 1ns/1ps
module ebc_far_side (
  // grant pin as driven by the block
  input wire logic grant_pin_n_out,
  input wire logic grant_pin_n_oe,
  // external master control
  input wire logic ext_take,
  input wire logic ext_level,
  // resolved pin level
  output logic grant_wire
);
  // the block's keeper is weak: an external master overrides it
  // whenever the block itself is not driving the pin
  assign grant_wire = grant_pin_n_oe ? grant_pin_n_out :
                      (ext_take ? ext_level : grant_pin_n_out);
endmodule : ebc_far_side

// File: dv/ebc_top_tb_top.sv
// self-checking bench for the port chip-enable block
`timescale 1ns/1ps
`include "ebc_cfg.svh"
module ebc_top_tb_top;
  import ebc_pkg::*;
  localparam logic [17:0] MAIN_A = 18'h3ff78;
  localparam logic [17:0] SEC_A = 18'h3ff68;
  logic clk, reset_n, cyc, stb, we, ack, mm, start, done, hold;
  logic [`EBC_ADR_W-1:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  ebc_space_t space;
  logic [15:0] aadr, padr, port_a, pa;
  logic mce_n, psel_n, g_in, g_out, g_oe, d_out, d_oe, ext_take, ext_lvl;
  int miscompares, check_count, cycles, mc, pc;

  ebc_top u_dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .master_mode(mm),
    .acc_start(start), .acc_space(space), .acc_addr(aadr),
    .program_address_bus(padr), .acc_done(done),
    .memory_chip_enable_n(mce_n), .peripheral_select_n(psel_n),
    .port_address(port_a), .bus_request_hold(hold),
    .grant_pin_n_in(g_in), .grant_pin_n_out(g_out), .grant_pin_n_oe(g_oe),
    .debug_request_pin_n_in(d_out), .debug_request_pin_n_out(d_out),
    .debug_request_pin_n_oe(d_oe));

  ebc_far_side u_far (.grant_pin_n_out(g_out), .grant_pin_n_oe(g_oe),
    .ext_take(ext_take), .ext_level(ext_lvl), .grant_wire(g_in));

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // classic single cycle; waits for ack, only the bound ends a hang
  task automatic wb(logic w, logic [17:0] a, logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= {16'h0000, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rchk(string what, logic [17:0] a, logic [15:0] exp);
    wb(1'b0, a, 16'h0000);
    check(what, q, {16'h0000, exp});
  endtask : rchk

  // one core access; counts strobe-low cycles and keeps the pins' address
  task automatic acc(ebc_space_t s, logic [15:0] a);
    mc = 0;
    pc = 0;
    pa = port_a;
    @(posedge clk);
    start <= 1'b1;
    space <= s;
    aadr <= (s == EBC_SP_PROG) ? ~a : a;
    padr <= (s == EBC_SP_PROG) ? a : ~a;
    @(posedge clk);
    start <= 1'b0;
    forever begin
      #1;
      if (mce_n === 1'b0) mc++;
      if (psel_n === 1'b0) pc++;
      if (mce_n === 1'b0 || psel_n === 1'b0) pa = port_a;
      if (done === 1'b1) break;
      @(posedge clk);
    end
  endtask : acc

  task automatic acc_chk(ebc_space_t s, logic [15:0] a, int emc, int epc);
    acc(s, a);
    check("memory strobe cycles", 32'(mc), 32'(emc));
    check("peripheral strobe cycles", 32'(pc), 32'(epc));
    check("port address", {16'h0000, pa}, {16'h0000, a});
  endtask : acc_chk

  task automatic t_reset();
    check("memory strobe idle", 32'(mce_n), 32'h1);
    check("peripheral strobe idle", 32'(psel_n), 32'h1);
    check("grant level", 32'(g_out), 32'h1);
    check("debug level", 32'(d_out), 32'h1);
    check("debug enable", 32'(d_oe), 32'h0);
    check("grant enable", 32'(g_oe), 32'h0);
    check("hold idle", 32'(hold), 32'h0);
    rchk("main control", MAIN_A, 16'h0021);
    rchk("second control", SEC_A, 16'h0000);
    rchk("unmapped", 18'h00010, 16'h0000);
  endtask : t_reset

  task automatic t_legacy();
    acc_chk(EBC_SP_DATA, 16'h1234, 2, 0);
    acc_chk(EBC_SP_PERIPH, 16'h0044, 1, 1);
    acc_chk(EBC_SP_PROG, 16'h0abc, 2, 0);
  endtask : t_legacy

  task automatic t_split();
    wb(1'b1, SEC_A, 16'h8002);
    rchk("second control", SEC_A, 16'h8002);
    acc_chk(EBC_SP_PERIPH, 16'h0055, 0, 3);
    acc_chk(EBC_SP_DATA, 16'h2000, 2, 0);
    @(posedge clk);
    mm <= 1'b0;
    repeat (3) @(posedge clk);
    acc_chk(EBC_SP_PERIPH, 16'h0066, 3, 3);
    mm <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b1, SEC_A, 16'h0002);
    acc_chk(EBC_SP_PERIPH, 16'h0077, 3, 3);
    wb(1'b1, SEC_A, 16'h0000);
  endtask : t_split

  task automatic t_grant();
    wb(1'b1, MAIN_A, 16'h2021);
    repeat (2) @(posedge clk);
    #1;
    check("grant forced level", 32'(g_out), 32'h0);
    check("grant forced enable", 32'(g_oe), 32'h1);
    repeat (4) @(posedge clk);
    rchk("main control", MAIN_A, 16'h6021);
    wb(1'b1, MAIN_A, 16'h0021);
    repeat (2) @(posedge clk);
    #1;
    check("grant released enable", 32'(g_oe), 32'h0);
    check("grant kept low", 32'(g_out), 32'h0);
    @(posedge clk);
    ext_take <= 1'b1;
    ext_lvl <= 1'b1;
    repeat (3) @(posedge clk);
    ext_take <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("grant kept high", 32'(g_out), 32'h1);
  endtask : t_grant

  task automatic t_padis();
    acc_chk(EBC_SP_PROG, 16'h0111, 2, 0);
    wb(1'b1, MAIN_A, 16'h1021);
    rchk("main control", MAIN_A, 16'h1021);
    // a fetch while gated is outside what software may do: only the
    // pins' address is judged, never the outcome of the transfer
    acc(EBC_SP_PROG, 16'h0222);
    check("gated address", {16'h0000, pa}, 32'h0111);
    acc_chk(EBC_SP_DATA, 16'h0333, 2, 0);
    acc_chk(EBC_SP_PERIPH, 16'h0344, 1, 1);
    wb(1'b1, MAIN_A, 16'h0021);
    @(posedge clk);
    acc_chk(EBC_SP_PROG, 16'h0444, 2, 0);
  endtask : t_padis

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    reset_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'h0;
    wdat = 32'h00000000;
    mm = 1'b1;
    start = 1'b0;
    space = EBC_SP_DATA;
    aadr = 16'h0000;
    padr = 16'h0000;
    ext_take = 1'b0;
    ext_lvl = 1'b1;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    t_legacy();
    t_split();
    t_grant();
    t_padis();
    close_out();
  end
endmodule : ebc_top_tb_top
